//--- dv/tb_tgr_top.sv
// Purpose: self-checking bench for the gesture recognizer
// Assumes: registers at index*4, frames spaced 26 cycles
// Notes: write strobes tied to all bytes
`timescale 1ns/1ps
`default_nettype none
module tb_tgr_top
  import tgr_pkg::*;
;
  logic clk, rst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0, cv = 1'b0;
  logic [15:0] aw = 16'h0, ar = 16'h0;
  logic [31:0] wd = 32'h0, d, rdata;
  logic [1:0] r, bresp, rresp;
  logic [9:0] msk = 10'h0;
  logic [159:0] cx = 160'h0, cy = 160'h0;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, sv, scv;
  logic [7:0] sid, sfl, sfn, cid, cfn, n_swp;
  logic [23:0] diam, last_swp;
  logic [15:0] ccx, ccy;
  logic [55:0] last_scr;
  logic [49:0] rows [5] = '{{16'h1400, 32'h00039387, RESP_OKAY}, {16'h1404, 32'h00000400, RESP_OKAY},
    {16'h1418, 32'h00000600, RESP_OKAY}, {16'h142C, 32'h00000200, RESP_OKAY}, {16'h1500, 32'h0, RESP_SLVERR}};
  int num_errors = 0, total_checks = 0, i;
  tgr_top i_tgr_top (.CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CT_VALID(cv),
    .CT_MASK(msk), .CT_X(cx), .CT_Y(cy), .SWP_VALID(sv), .SWP_ID(sid), .SWP_FLAGS(sfl), .SWP_FINGERS(sfn),
    .SCR_VALID(scv), .SCR_ID(cid), .SCR_FINGERS(cfn), .SCR_DIAM(diam), .SCR_CX(ccx), .SCR_CY(ccy));
  tgr_host i_tgr_host (.clk(clk), .rst(rst), .swp_v(sv), .swp({sid, sfl, sfn}), .scr_v(scv),
    .scr({cfn, diam, ccx, ccy}), .n_swp(n_swp), .last_swp(last_swp), .last_scr(last_scr));
  // ****************
  // tasks
  // ****************
  task end_of_test;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded waits: a hang counts as an error and closes the run
  task wr(input logic [15:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    aw <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (bvalid === 1'b1) break;
      if (awrdy === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end
    if (n == 50) begin num_errors++; end_of_test; end
    bready <= 1'b0;
    chk(bresp, RESP_OKAY);
  endtask
  task rd(input logic [15:0] a);
    int n;
    @(posedge clk);
    ar <= a; arv <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin @(posedge clk); if (arrdy === 1'b1) break; end
    arv <= 1'b0;
    for (i = 0; i < 50 && n < 50; i++) begin @(posedge clk); if (rvalid === 1'b1) break; end
    if (n == 50 || i == 50) begin num_errors++; end_of_test; end
    d = rdata; r = rresp; rready <= 1'b0;
  endtask
  // one frame, then enough idle cycles for the scroll message to land
  task frm(input logic [9:0] m, input logic [15:0] x0, y0, x1, y1);
    @(posedge clk);
    msk <= m; cx <= {128'h0, x1, x0}; cy <= {128'h0, y1, y0}; cv <= 1'b1;
    @(posedge clk);
    cv <= 1'b0;
    repeat (24) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 5; k++) begin rd(rows[k][49:34]); chk({d, r}, rows[k][33:0]); end
    wr(16'h142C, 32'h12340300); rd(16'h142C); chk(d, 32'h300);
    chk({sid, cid}, 16'hA0A1);
    frm(10'h3, 16'h0800, 16'h0100, 16'h0900, 16'h0500); // two fingers on the north band
    chk(last_scr, {8'h02, 16'h041F, 16'h0880, 16'h0300});
    chk(n_swp, 8'h00);
    frm(10'h3, 16'h0800, 16'h0501, 16'h0900, 16'h0901);
    chk({n_swp, last_swp}, {8'h01, 8'hA0, 8'h01, 8'h02});
    frm(10'h3, 16'h0800, 16'h0C00, 16'h0900, 16'h1000); // further travel must stay silent
    chk(n_swp, 8'h01);
    frm(10'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    frm(10'h1, 16'h0800, 16'h1000, 16'h0, 16'h0); // single finger in the middle
    frm(10'h1, 16'h0C01, 16'h1000, 16'h0, 16'h0);
    chk({n_swp, last_swp}, {8'h02, 8'hA0, 8'h80, 8'h01});
    // output gate off: detection still runs, but no pulse may reach the host
    frm(10'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    wr(16'h1430, 32'h00000001);
    frm(10'h1, 16'h0800, 16'h1000, 16'h0, 16'h0);
    frm(10'h1, 16'h0C01, 16'h1000, 16'h0, 16'h0);
    chk(n_swp, 8'h02);
    // zero time limit: the edge window is already closed at first touch
    frm(10'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    wr(16'h1430, 32'h00000003);
    wr(16'h1400, 32'h00000000);
    frm(10'h3, 16'h0800, 16'h0100, 16'h0900, 16'h0500);
    frm(10'h3, 16'h0800, 16'h0501, 16'h0900, 16'h0901);
    chk(n_swp, 8'h02);
    // fingers on opposite edges: no edge start and no middle mode either
    frm(10'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    frm(10'h3, 16'h0800, 16'h0100, 16'h0900, 16'h2200);
    frm(10'h3, 16'h0C01, 16'h0100, 16'h0D01, 16'h2200);
    chk(n_swp, 8'h02);
    end_of_test;
  end
endmodule
`default_nettype wire

//--- dv/tgr_host.sv
// Purpose: host end that takes gesture messages
// Assumes: one-cycle message pulses on clk
// Notes: keeps a swipe count and the last message of each kind
`timescale 1ns/1ps
`default_nettype none
module tgr_host
  import tgr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        swp_v,
  input  wire logic [23:0] swp,
  input  wire logic        scr_v,
  input  wire logic [63:0] scr,
  output logic [7:0]       n_swp,
  output logic [23:0]      last_swp,
  output logic [55:0]      last_scr
);
  // latch messages; upper diagonal byte is dropped, though it carries bit 16 of the root
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n_swp    <= 8'h00;
      last_swp <= 24'h000000;
      last_scr <= 56'h0;
    end else begin
      if (swp_v) begin
        n_swp    <= n_swp + 8'h01;
        last_swp <= swp;
      end
      if (scr_v) last_scr <= {scr[63:56], scr[47:0]};
    end
  end
endmodule
`default_nettype wire

//--- hw/tgr_top.sv
// Purpose: swipe and scroll gesture recognizer with AXI4-Lite registers
// Assumes: contact frames come from logic on CLK, one slot per finger
// Notes: edge bits [0]N [1]E [2]S [3]W; middle bits [0]S [1]W [2]N [3]E
`timescale 1ns/1ps
`default_nettype none
module tgr_top
  import tgr_pkg::*;
#(
  parameter int MAX_CONTACTS = 10
) (
  input  wire logic                      CLK,
  input  wire logic                      SYS_RST,
  input  wire logic [15:0]               S_AXI_AWADDR,
  input  wire logic                      S_AXI_AWVALID,
  output logic                           S_AXI_AWREADY,
  input  wire logic [31:0]               S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  input  wire logic                      S_AXI_WVALID,
  output logic                           S_AXI_WREADY,
  output logic [1:0]                     S_AXI_BRESP,
  output logic                           S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  input  wire logic [15:0]               S_AXI_ARADDR,
  input  wire logic                      S_AXI_ARVALID,
  output logic                           S_AXI_ARREADY,
  output logic [31:0]                    S_AXI_RDATA,
  output logic [1:0]                     S_AXI_RRESP,
  output logic                           S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY,
  input  wire logic                      CT_VALID,
  input  wire logic [MAX_CONTACTS-1:0]   CT_MASK,
  input  wire logic [MAX_CONTACTS*16-1:0] CT_X,
  input  wire logic [MAX_CONTACTS*16-1:0] CT_Y,
  output logic                           SWP_VALID,
  output logic [7:0]                     SWP_ID,
  output logic [7:0]                     SWP_FLAGS,
  output logic [7:0]                     SWP_FINGERS,
  output logic                           SCR_VALID,
  output logic [7:0]                     SCR_ID,
  output logic [7:0]                     SCR_FINGERS,
  output logic [23:0]                    SCR_DIAM,
  output logic [15:0]                    SCR_CX,
  output logic [15:0]                    SCR_CY
);
  // slot count must fit the 4-bit finger counter
  if (MAX_CONTACTS < 1 || MAX_CONTACTS > 15) begin : g_bad
    $error("MAX_CONTACTS out of range");
  end

  // ***************************************************
  // register bus
  // ***************************************************
  logic [31:0] regs_r [NREG];
  logic [1:0]  ctrl_r;
  logic        aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [15:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [3:0]  w_strb_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rd_val, status;
  logic        rd_ok, wr_ok, do_wr;
  logic [3:0]  wr_i, rd_i;
  logic [13:0] aw_idx, ar_idx;
  logic        en, out_en;

  assign en     = ctrl_r[CTRL_EN];
  assign out_en = ctrl_r[CTRL_OUT];
  assign aw_idx = aw_addr_r[15:2];
  assign ar_idx = S_AXI_ARADDR[15:2];
  assign wr_i   = 4'(aw_idx - IDX_SWIPE_TIME_LIMIT);
  assign rd_i   = 4'(ar_idx - IDX_SWIPE_TIME_LIMIT);
  assign wr_ok  = aw_addr_r[1:0] == 2'h0 && aw_idx >= IDX_SWIPE_TIME_LIMIT && aw_idx <= IDX_CTRL;
  // address and data each wait in a holding slot until both are in
  assign S_AXI_AWREADY = !aw_hold_r && !bvalid_r;
  assign S_AXI_WREADY  = !w_hold_r && !bvalid_r;
  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;

  // write channel capture and response
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      aw_addr_r <= 16'h0000;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // register storage, byte lanes merged then cut to the field width
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < NREG; i++) begin
        regs_r[i] <= RST_VAL[i];
      end
      ctrl_r <= CTRL_RST;
    end else if (do_wr && wr_ok) begin
      if (aw_idx == IDX_CTRL) begin
        if (w_strb_r[0]) begin
          ctrl_r <= w_data_r[1:0];
        end
      end else begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb_r[b]) begin
            regs_r[wr_i][8*b +: 8] <= w_data_r[8*b +: 8]
              & ((wr_i == 4'h0) ? MASK_W32[8*b +: 8] : MASK_W16[8*b +: 8]);
          end
        end
      end
    end
  end

  // read decode; unmapped or misaligned reads answer zero with an error
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok  = S_AXI_ARADDR[1:0] == 2'h0;
    if (ar_idx >= IDX_SWIPE_TIME_LIMIT && ar_idx <= IDX_MIDDLE_LATERAL_MAX) begin
      rd_val = regs_r[rd_i];
    end else if (ar_idx == IDX_CTRL) begin
      rd_val = {30'h0, ctrl_r};
    end else if (ar_idx == IDX_STATUS) begin
      rd_val = status;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_ok ? rd_val : 32'h00000000;
      rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // ***************************************************
  // per-slot geometry
  // ***************************************************
  logic [15:0] px [MAX_CONTACTS];
  logic [15:0] py [MAX_CONTACTS];
  logic [15:0] sx_r [MAX_CONTACTS];
  logic [15:0] sy_r [MAX_CONTACTS];
  logic [3:0]  narrow [MAX_CONTACTS];
  logic [3:0]  wide   [MAX_CONTACTS];
  logic [3:0]  etrav  [MAX_CONTACTS];
  logic [3:0]  ctrav  [MAX_CONTACTS];
  logic signed [16:0] tmin, mmin;
  logic [16:0] mlat;

  assign tmin = $signed({1'b0, regs_r[1][15:0]});
  assign mmin = $signed({1'b0, regs_r[10][15:0]});
  assign mlat = {1'b0, regs_r[11][15:0]};

  // raw coordinates only, no scaling or flip anywhere on this path
  for (genvar s = 0; s < MAX_CONTACTS; s++) begin : g_slot
    logic signed [16:0] dx, dy;
    logic [16:0] adx, ady;
    assign px[s] = CT_X[s*16 +: 16];
    assign py[s] = CT_Y[s*16 +: 16];
    assign dx  = $signed({1'b0, px[s]}) - $signed({1'b0, sx_r[s]});
    assign dy  = $signed({1'b0, py[s]}) - $signed({1'b0, sy_r[s]});
    assign adx = dx[16] ? 17'(-dx) : 17'(dx);
    assign ady = dy[16] ? 17'(-dy) : 17'(dy);
    // band membership; a corner sits in two bands at once
    assign narrow[s] = {px[s] < regs_r[2][15:0], py[s] > regs_r[5][15:0],
                        px[s] > regs_r[3][15:0], py[s] < regs_r[4][15:0]};
    assign wide[s]   = {px[s] < regs_r[6][15:0], py[s] > regs_r[9][15:0],
                        px[s] > regs_r[7][15:0], py[s] < regs_r[8][15:0]};
    // travel toward the middle along the edge's own axis
    assign etrav[s] = {dx > tmin, -dy > tmin, -dx > tmin, dy > tmin};
    assign ctrav[s] = {dx > mmin && ady <= mlat, -dy > mmin && adx <= mlat,
                       -dx > mmin && ady <= mlat, dy > mmin && adx <= mlat};
  end

  // ***************************************************
  // frame reduction
  // ***************************************************
  logic [3:0]  cnt;
  logic [19:0] sum_x, sum_y;
  logic [15:0] min_x, max_x, min_y, max_y;
  logic [3:0]  n_any, w_all, e_all, c_all, edge_sel, mid_sel;
  logic [MAX_CONTACTS-1:0] seen_r;

  always_comb begin
    cnt = 4'h0;
    sum_x = 20'h00000;
    sum_y = 20'h00000;
    min_x = 16'hFFFF;
    min_y = 16'hFFFF;
    max_x = 16'h0000;
    max_y = 16'h0000;
    n_any = 4'h0;
    w_all = 4'hF;
    e_all = 4'hF;
    c_all = 4'hF;
    for (int s = 0; s < MAX_CONTACTS; s++) begin
      if (CT_MASK[s]) begin
        cnt = cnt + 4'h1;
        sum_x = sum_x + 20'(px[s]);
        sum_y = sum_y + 20'(py[s]);
        if (px[s] < min_x) min_x = px[s];
        if (px[s] > max_x) max_x = px[s];
        if (py[s] < min_y) min_y = py[s];
        if (py[s] > max_y) max_y = py[s];
        n_any = n_any | narrow[s];
        w_all = w_all & wide[s];
        // a finger with no start yet has not travelled
        e_all = e_all & (seen_r[s] ? etrav[s] : 4'h0);
        c_all = c_all & (seen_r[s] ? ctrav[s] : 4'h0);
      end
    end
  end

  // lowest set bit picks one edge or direction only
  assign edge_sel = (n_any & w_all) & (~(n_any & w_all) + 4'h1);
  assign mid_sel  = c_all & (~c_all + 4'h1);

  // ***************************************************
  // timeout ticks
  // ***************************************************
  logic [9:0]  tick_cnt_r;
  logic [31:0] timer_r;
  logic        tick, restart, expired, touching_r;

  assign restart = CT_VALID && en && !touching_r && cnt != 4'h0;
  assign tick    = tick_cnt_r == 10'(TICK_DIV - 1);
  assign expired = timer_r >= regs_r[0];

  // prescaler and tick counter restart at the first touch
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_cnt_r <= 10'h000;
      timer_r    <= 32'h00000000;
    end else if (restart) begin
      tick_cnt_r <= 10'h000;
      timer_r    <= 32'h00000000;
    end else begin
      tick_cnt_r <= tick ? 10'h000 : tick_cnt_r + 10'h001;
      if (tick && timer_r != 32'hFFFFFFFF) begin
        timer_r <= timer_r + 32'h00000001;
      end
    end
  end

  // ***************************************************
  // swipe tracking
  // ***************************************************
  logic [3:0] edge_r;
  logic       mid_r, susp_r, swp_valid_r;
  logic [7:0] swp_flags_r, swp_fingers_r;

  // each slot's start is caught on its first appearance
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      seen_r <= '0;
      for (int s = 0; s < MAX_CONTACTS; s++) begin
        sx_r[s] <= 16'h0000;
        sy_r[s] <= 16'h0000;
      end
    end else if (!en || (CT_VALID && cnt == 4'h0)) begin
      seen_r <= '0;
    end else if (CT_VALID) begin
      seen_r <= seen_r | CT_MASK;
      for (int s = 0; s < MAX_CONTACTS; s++) begin
        if (CT_MASK[s] && !seen_r[s]) begin
          sx_r[s] <= px[s];
          sy_r[s] <= py[s];
        end
      end
    end
  end

  // start classification, travel check and suspension until lift-off
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      touching_r    <= 1'b0;
      edge_r        <= 4'h0;
      mid_r         <= 1'b0;
      susp_r        <= 1'b0;
      swp_valid_r   <= 1'b0;
      swp_flags_r   <= 8'h00;
      swp_fingers_r <= 8'h00;
    end else begin
      swp_valid_r <= 1'b0;
      if (!en) begin
        touching_r <= 1'b0;
        susp_r     <= 1'b0;
      end else if (CT_VALID && cnt == 4'h0) begin
        touching_r <= 1'b0;
        susp_r     <= 1'b0;
      end else if (CT_VALID && !touching_r) begin
        touching_r <= 1'b1;
        edge_r     <= edge_sel;
        mid_r      <= n_any == 4'h0;
        // fingers near edges but not on a common one end swipe detection
        susp_r     <= edge_sel == 4'h0 && n_any != 4'h0;
      end else if (CT_VALID && !susp_r) begin
        if (edge_r != 4'h0) begin
          if (expired) begin
            susp_r <= 1'b1;
          end else if ((e_all & edge_r) != 4'h0) begin
            susp_r        <= 1'b1;
            swp_valid_r   <= out_en;
            swp_flags_r   <= {4'h0, edge_r};
            swp_fingers_r <= {4'h0, cnt};
          end
        end else if (mid_r && c_all != 4'h0) begin
          susp_r        <= 1'b1;
          swp_valid_r   <= out_en;
          swp_flags_r   <= {mid_sel, 4'h0};
          swp_fingers_r <= {4'h0, cnt};
        end
      end
    end
  end

  assign SWP_VALID   = swp_valid_r;
  assign SWP_ID      = MSG_SWIPE;
  assign SWP_FLAGS   = swp_flags_r;
  assign SWP_FINGERS = swp_fingers_r;

  // ***************************************************
  // scroll data
  // ***************************************************
  tgr_state_t  st_r;
  logic [15:0] bw_r, bh_r, cx_r, cy_r;
  logic [3:0]  fing_r;
  logic [32:0] sq_r;
  logic [16:0] root_r, cand;
  logic [4:0]  bit_r;
  logic        scr_valid_r;

  assign cand = root_r | (17'h00001 << bit_r);

  // frames that land while a root is in progress are skipped
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r        <= ST_IDLE;
      bw_r        <= 16'h0000;
      bh_r        <= 16'h0000;
      cx_r        <= 16'h0000;
      cy_r        <= 16'h0000;
      fing_r      <= 4'h0;
      sq_r        <= 33'h000000000;
      root_r      <= 17'h00000;
      bit_r       <= 5'h00;
      scr_valid_r <= 1'b0;
    end else begin
      scr_valid_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (CT_VALID && en && cnt != 4'h0) begin
            bw_r   <= max_x - min_x;
            bh_r   <= max_y - min_y;
            cx_r   <= 16'(sum_x / {16'h0000, cnt});
            cy_r   <= 16'(sum_y / {16'h0000, cnt});
            fing_r <= cnt;
            sq_r   <= 33'(32'(max_x - min_x) * 32'(max_x - min_x))
                    + 33'(32'(max_y - min_y) * 32'(max_y - min_y));
            root_r <= 17'h00000;
            bit_r  <= 5'h10;
            st_r   <= ST_ROOT;
          end
        end
        // one result bit per cycle, largest first
        ST_ROOT: begin
          if (34'(cand) * 34'(cand) <= 34'(sq_r)) begin
            root_r <= cand;
          end
          if (bit_r == 5'h00) begin
            st_r <= ST_SEND;
          end else begin
            bit_r <= bit_r - 5'h01;
          end
        end
        ST_SEND: begin
          scr_valid_r <= out_en;
          st_r        <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign SCR_VALID   = scr_valid_r;
  assign SCR_ID      = MSG_SCROLL;
  assign SCR_FINGERS = {4'h0, fing_r};
  assign SCR_DIAM    = {7'h00, root_r};
  assign SCR_CX      = cx_r;
  assign SCR_CY      = cy_r;
  assign status = {20'h0, st_r != ST_IDLE, mid_r, edge_r, susp_r, touching_r, fing_r};

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  property p_fingers;
    SCR_VALID |-> SCR_FINGERS >= 8'h01 && SCR_FINGERS <= 8'(MAX_CONTACTS);
  endproperty
  a_fingers: assert property (p_fingers) else $error("scroll finger count out of range");

  property p_gate;
    (SWP_VALID || SCR_VALID) |-> en && out_en;
  endproperty
  a_gate: assert property (p_gate) else $error("message while gated off");

  property p_onehot;
    SWP_VALID |-> $onehot(SWP_FLAGS) && SWP_FINGERS != 8'h00;
  endproperty
  a_onehot: assert property (p_onehot) else $error("swipe flags not one-hot");

  property p_edge_time;
    SWP_VALID && SWP_FLAGS[3:0] != 4'h0 |-> !$past(expired) && SWP_FLAGS[3:0] == $past(edge_r);
  endproperty
  a_edge_time: assert property (p_edge_time) else $error("edge swipe after timeout");

  property p_suspend;
    SWP_VALID |-> susp_r ##1 (!SWP_VALID)[*3];
  endproperty
  a_suspend: assert property (p_suspend) else $error("swipe repeated before lift");

  property p_tick;
    tick && !restart |=> (!tick)[*8];
  endproperty
  a_tick: assert property (p_tick) else $error("tick spacing too short");

  property p_diag;
    SCR_VALID |-> SCR_DIAM >= {8'h00, bw_r} && SCR_DIAM >= {8'h00, bh_r} && SCR_DIAM[23:17] == 7'h00;
  endproperty
  a_diag: assert property (p_diag) else $error("diagonal shorter than box side");

  property p_scroll_seq;
    $rose(st_r == ST_ROOT) |-> ##17 st_r == ST_SEND ##1 (SCR_VALID == out_en);
  endproperty
  a_scroll_seq: assert property (p_scroll_seq) else $error("scroll report late");

endmodule
`default_nettype wire

//--- pkg/tgr_pkg.sv
// Purpose: shared constants for the touch gesture recognizer
// Assumes: 100 MHz clock, registers reached over AXI4-Lite
// Notes: register numbers are word indices, byte address = index * 4
package tgr_pkg;
  // ***************************************************
  // timing
  // ***************************************************
  localparam int unsigned CLK_HZ   = 100_000_000;
  localparam int unsigned TICK_HZ  = 156_250;
  localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
  // ***************************************************
  // register indices
  // ***************************************************
  localparam int NREG = 12;
  localparam logic [13:0] IDX_SWIPE_TIME_LIMIT   = 14'h0500;
  localparam logic [13:0] IDX_SWIPE_TRAVEL_MIN   = 14'h0501;
  localparam logic [13:0] IDX_NARROW_BAND_LEFT   = 14'h0502;
  localparam logic [13:0] IDX_NARROW_BAND_RIGHT  = 14'h0503;
  localparam logic [13:0] IDX_NARROW_BAND_TOP    = 14'h0504;
  localparam logic [13:0] IDX_NARROW_BAND_BOTTOM = 14'h0505;
  localparam logic [13:0] IDX_WIDE_BAND_LEFT     = 14'h0506;
  localparam logic [13:0] IDX_WIDE_BAND_RIGHT    = 14'h0507;
  localparam logic [13:0] IDX_WIDE_BAND_TOP      = 14'h0508;
  localparam logic [13:0] IDX_WIDE_BAND_BOTTOM   = 14'h0509;
  localparam logic [13:0] IDX_MIDDLE_TRAVEL_MIN  = 14'h050A;
  localparam logic [13:0] IDX_MIDDLE_LATERAL_MAX = 14'h050B;
  localparam logic [13:0] IDX_CTRL               = 14'h050C;
  localparam logic [13:0] IDX_STATUS             = 14'h050D;
  // reset values and writable width, in index order
  localparam logic [31:0] RST_VAL [NREG] = '{
    32'h00039387, 32'h00000400, 32'h00000300, 32'h00001100,
    32'h00000300, 32'h00002100, 32'h00000600, 32'h00000D9C,
    32'h00000600, 32'h00001E00, 32'h00000400, 32'h00000200};
  localparam logic [31:0] MASK_W32 = 32'hFFFFFFFF;
  localparam logic [31:0] MASK_W16 = 32'h0000FFFF;
  localparam logic [1:0]  CTRL_RST = 2'h3;
  localparam int CTRL_EN  = 0;
  localparam int CTRL_OUT = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ***************************************************
  // messages
  // ***************************************************
  localparam logic [7:0] MSG_SWIPE  = 8'hA0;
  localparam logic [7:0] MSG_SCROLL = 8'hA1;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ROOT = 3'h2,
    ST_SEND = 3'h4
  } tgr_state_t;
endpackage
